// File: design/dmt_timer_unit.sv
// five-timer, two-module general purpose timer unit
// Functional notes
// R01: five 16-bit timers; module a has three, module b two plus capture_reload_register
// R02: timers run alone or chain only inside their own module
// R03: module a timers select timer, gated timer or counter mode
// R04: module a prescaler codes 0..7 give divide by 8 up to 1024
// R05: counter mode advances on edges of the timer input pin
// R06: gated mode counts prescaled ticks only while gate pin active
// R07: each module a timer has one pin: gate or count clock
// R08: module a direction from software bit or external direction pin
// R09: core a toggle latch inverts on every overflow and underflow
// R10: core a latch drives a pin and can clock either aux timer
// R11: aux a timer as reload or capture register stops counting
// R12: aux a capture copies core a value on its pin edge
// R13: aux a reload loads core a on pin edge or latch transition
// R14: opposite-edge reloads from both aux timers give free PWM
// R15: module b prescaler codes 0..7 give divide by 4 up to 512
// R16: module b direction from software, optionally from direction pin
// R17: core b toggle latch inverts on every overflow and underflow
// R18: core b latch can clock aux b and drives its own pin
// R19: core b over/underflow offered as clock to compare/capture unit
// R20: core b over/underflow can trigger reload from capture_reload_register
// R21: capture_reload_register latches aux b value on selected capture pin edge
// R22: with clear enabled aux b is zeroed right after capture
// R23: core b reload writes capture_reload_register contents into core b
// R24: each timer flags its over/underflow; capture_reload_register flags each capture
`timescale 1ns/1ps

module dmt_timer_unit (
  input wire logic clock,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [4:0] timer_gate_clock_pin,
  input wire logic [4:0] direction_control_pin,
  input wire logic capture_input_pin,
  output logic toggle_output_pin,
  output logic core_b_toggle_pin,
  output logic compare_capture_unit_clock,
  output logic [5:0] irq_request
);

`include "dmt_defines.svh"

  dmt_pkg::dmt_state_s q;
  dmt_pkg::dmt_state_s d;
  logic [4:0] ev;
  logic [4:0] inc;
  logic [4:0] ph;
  logic cb;

  // ------------------------------------------------------------
  // edge code: bit 0 rising, bit 1 falling
  // ------------------------------------------------------------
  function automatic logic edge_hit(
    input logic [1:0] code,
    input logic rise,
    input logic fall
  );
    edge_hit = (code[0] & rise) | (code[1] & fall);
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    dmt_pkg::dmt_mode_e mode;
    logic [9:0] mask;
    logic [2:0] sel;
    logic [10:0] rise;
    logic [10:0] fall;
    logic [1:0] lr;
    logic [1:0] lf;
    logic tick;
    logic src;
    logic down;
    logic trig;
    logic tr_r;
    logic tr_f;
    logic [2:0] widx;
    mode = dmt_pkg::mode_timer;
    mask = '0;
    sel = '0;
    tick = 1'b0;
    src = 1'b0;
    down = 1'b0;
    trig = 1'b0;
    widx = '0;
    rise = '0;
    fall = '0;
    lr = '0;
    lf = '0;
    tr_r = 1'b0;
    tr_f = 1'b0;
    ev = '0;
    inc = '0;
    ph = '0;
    d = q;
    // pins cross in through two flops; third flop only for edges
    d.s1 = {capture_input_pin, direction_control_pin,
            timer_gate_clock_pin};
    d.s2 = q.s1;
    d.s3 = q.s2;
    rise = q.s2 & ~q.s3;
    fall = ~q.s2 & q.s3;
    d.pre = q.pre + 10'h001;
    d.latp = q.lat;
    // latch edges seen one cycle late, so aux counts lag by one clock
    lr = q.lat & ~q.latp;
    lf = ~q.lat & q.latp;
    d.rdata = '0;

    for (int i = 0; i < 5; i++) begin
      sel = q.con[i][`DMT_F_SEL];
      mode = dmt_pkg::dmt_mode_e'(q.con[i][`DMT_F_MODE]);
      if (i < 3) begin
        mask = ~(`DMT_PRE_A_NMASK << sel); // see R04
      end else begin
        mask = ~(`DMT_PRE_B_NMASK << sel); // see R15
      end
      tick = (q.pre & mask) == mask;
      ph[i] = edge_hit(sel[`DMT_F_EDGE], rise[i], fall[i]); // see R07
      if (q.con[i][`DMT_B_LATSRC] && i != `DMT_CORE_A
          && i != `DMT_CORE_B) begin
        if (i < 3) begin
          src = edge_hit(sel[`DMT_F_EDGE], lr[0], lf[0]); // see R10 R02
        end else begin
          src = edge_hit(sel[`DMT_F_EDGE], lr[1], lf[1]); // see R18
        end
      end else begin
        src = ph[i]; // see R05
      end
      down = q.con[i][`DMT_B_DOWN] ^ (q.con[i][`DMT_B_EXTDIR]
             & q.s2[`DMT_PIN_DIR0 + i]); // see R08 R16
      unique case (mode)
        dmt_pkg::mode_timer: inc[i] = tick; // see R03
        dmt_pkg::mode_counter: inc[i] = src;
        dmt_pkg::mode_gate_low: inc[i] = tick & ~q.s2[i]; // see R06
        dmt_pkg::mode_gate_high: inc[i] = tick & q.s2[i];
        dmt_pkg::mode_reload: inc[i] = 1'b0; // see R11
        dmt_pkg::mode_capture: inc[i] = 1'b0;
        default: inc[i] = 1'b0;
      endcase
      inc[i] = inc[i] & q.con[i][`DMT_B_RUN];
      if (down) begin
        ev[i] = inc[i] & (q.cnt[i] == `DMT_CNT_MIN);
        if (inc[i]) begin
          d.cnt[i] = q.cnt[i] - 16'h0001;
        end
      end else begin
        ev[i] = inc[i] & (q.cnt[i] == `DMT_CNT_MAX); // see R01
        if (inc[i]) begin
          d.cnt[i] = q.cnt[i] + 16'h0001;
        end
      end
    end

    // ------------------------------------------------------------
    // module a: core latch, reload and capture roles
    // ------------------------------------------------------------
    d.lat[0] = q.lat[0] ^ ev[`DMT_CORE_A]; // see R09
    tr_r = ev[`DMT_CORE_A] & ~q.lat[0];
    tr_f = ev[`DMT_CORE_A] & q.lat[0];
    // high aux wins if both reload in one cycle
    for (int j = 0; j < 3; j += 2) begin
      mode = dmt_pkg::dmt_mode_e'(q.con[j][`DMT_F_MODE]);
      sel = q.con[j][`DMT_F_SEL];
      if (sel[`DMT_B_LATSRC]) begin
        trig = edge_hit(sel[`DMT_F_EDGE], tr_r, tr_f); // see R14
      end else begin
        trig = ph[j];
      end
      if (mode == dmt_pkg::mode_reload && trig) begin
        d.cnt[`DMT_CORE_A] = q.cnt[j]; // see R13
      end
      if (mode == dmt_pkg::mode_capture && ph[j]) begin
        d.cnt[j] = q.cnt[`DMT_CORE_A]; // see R12
      end
    end

    // ------------------------------------------------------------
    // module b: core latch, capture_reload_register reload and capture
    // ------------------------------------------------------------
    d.lat[1] = q.lat[1] ^ ev[`DMT_CORE_B]; // see R17
    if (ev[`DMT_CORE_B] && q.con[`DMT_CORE_B][`DMT_B_RELOAD]) begin
      d.cnt[`DMT_CORE_B] = q.cap; // see R20 R23
    end
    d.t6ev = ev[`DMT_CORE_B]; // see R19

    // ------------------------------------------------------------
    // register writes; timer values from software beat counting
    // ------------------------------------------------------------
    if (wr) begin
      if (addr <= `DMT_ADDR_CON_LAST) begin
        d.con[addr[2:0]] = wdata;
      end else if (addr <= `DMT_ADDR_CNT_LAST) begin
        widx = 3'(addr - `DMT_ADDR_CNT_FIRST);
        d.cnt[widx] = wdata;
      end else if (addr == `DMT_ADDR_CAPTURE_RELOAD_REGISTER) begin
        d.cap = wdata;
      end
    end

    // a capture arriving with a software write still lands
    cb = edge_hit(q.con[`DMT_AUX_B][`DMT_F_CAPEDGE],
                  rise[`DMT_PIN_CAP], fall[`DMT_PIN_CAP])
         & q.con[`DMT_AUX_B][`DMT_B_CAPEN];
    if (cb) begin
      d.cap = q.cnt[`DMT_AUX_B]; // see R21
      if (q.con[`DMT_AUX_B][`DMT_B_CLR]) begin
        d.cnt[`DMT_AUX_B] = `DMT_CNT_MIN; // see R22
      end
    end

    // flags: write one clears, a new event in that cycle still sets
    if (wr && addr == `DMT_ADDR_FLAGS) begin
      d.flg = q.flg & ~wdata[5:0];
    end
    d.flg = d.flg | {cb, ev}; // see R24

    d.tog[0] = d.lat[0] & q.con[`DMT_CORE_A][`DMT_B_OUTEN]; // see R10
    d.tog[1] = d.lat[1] & q.con[`DMT_CORE_B][`DMT_B_OUTEN]; // see R18

    if (rd) begin
      if (addr <= `DMT_ADDR_CON_LAST) begin
        d.rdata = q.con[addr[2:0]];
      end else if (addr <= `DMT_ADDR_CNT_LAST) begin
        widx = 3'(addr - `DMT_ADDR_CNT_FIRST);
        d.rdata = q.cnt[widx];
      end else if (addr == `DMT_ADDR_CAPTURE_RELOAD_REGISTER) begin
        d.rdata = q.cap;
      end else if (addr == `DMT_ADDR_FLAGS) begin
        d.rdata = {10'h000, q.flg};
      end else if (addr == `DMT_ADDR_STATUS) begin
        d.rdata = {3'h0, q.s2, q.lat};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign toggle_output_pin = q.tog[0];
  assign core_b_toggle_pin = q.tog[1];
  assign compare_capture_unit_clock = q.t6ev;
  assign irq_request = q.flg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_lat_a;
    @(posedge clock) disable iff (reset)
      ev[1] |=> q.lat[0] != $past(q.lat[0]);
  endproperty
  a_lat_a: assert property (p_lat_a) // see R09
    else $error("core a latch did not toggle");

  property p_lat_b;
    @(posedge clock) disable iff (reset)
      ev[4] |=> q.lat[1] != $past(q.lat[1]) ##0 q.t6ev;
  endproperty
  a_lat_b: assert property (p_lat_b) // see R17
    else $error("core b latch or event pulse missing");

  property p_flag;
    @(posedge clock) disable iff (reset)
      (ev[1] |=> irq_request[1]) and
        (ev[4] |=> irq_request[4]);
  endproperty
  a_flag: assert property (p_flag) // see R24
    else $error("timer event flag not set");

  property p_cap_a;
    @(posedge clock) disable iff (reset)
      q.con[2][5:3] == 3'h5 && ph[2] && !wr |=>
        q.cnt[2] == $past(q.cnt[1]);
  endproperty
  a_cap_a: assert property (p_cap_a) // see R12
    else $error("aux a capture value wrong");

  property p_cap_b;
    @(posedge clock) disable iff (reset)
      cb |=> q.cap == $past(q.cnt[3]) && irq_request[5];
  endproperty
  a_cap_b: assert property (p_cap_b) // see R21
    else $error("capture_reload_register capture value wrong");

  property p_clr;
    @(posedge clock) disable iff (reset)
      cb && q.con[3][12] && !wr |=> q.cnt[3] == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) // see R22
    else $error("aux b not cleared after capture");

  property p_reload_b;
    @(posedge clock) disable iff (reset)
      ev[4] && q.con[4][10] && !wr |=> q.cnt[4] == $past(q.cap);
  endproperty
  a_reload_b: assert property (p_reload_b) // see R20
    else $error("core b reload from capture_reload_register missing");

  property p_stop;
    @(posedge clock) disable iff (reset)
      q.con[0][5:3] == 3'h4 && !wr |=> $stable(q.cnt[0]);
  endproperty
  a_stop: assert property (p_stop) // see R11
    else $error("aux timer in reload role moved");

  property p_tick;
    @(posedge clock) disable iff (reset)
      inc[1] && q.con[1][5:3] == 3'h0 |-> q.pre[2:0] == 3'h7;
  endproperty
  a_tick: assert property (p_tick) // see R04
    else $error("core a counted off prescaler tick");

  property p_pre_b;
    @(posedge clock) disable iff (reset)
      inc[4] && q.con[4][5:3] == 3'h0 |-> q.pre[1:0] == 2'h3;
  endproperty
  a_pre_b: assert property (p_pre_b) // see R15
    else $error("core b counted off prescaler tick");

  property p_reload_a;
    @(posedge clock) disable iff (reset)
      q.con[0][5:3] == 3'h4 && !q.con[0][2] && ph[0] &&
        q.con[2][5:3] != 3'h4 && !wr |=> q.cnt[1] == $past(q.cnt[0]);
  endproperty
  a_reload_a: assert property (p_reload_a) // see R13
    else $error("core a reload from aux low missing");

  property p_gate_hi;
    @(posedge clock) disable iff (reset)
      q.con[2][5:3] == 3'h3 && !q.s2[2] |-> !inc[2];
  endproperty
  a_gate_hi: assert property (p_gate_hi) // see R06
    else $error("aux high counted with gate inactive");

  property p_gate_lo;
    @(posedge clock) disable iff (reset)
      q.con[2][5:3] == 3'h2 && q.s2[2] |-> !inc[2];
  endproperty
  a_gate_lo: assert property (p_gate_lo) // see R06
    else $error("aux high counted with low gate inactive");

  property p_tog_a;
    @(posedge clock) disable iff (reset)
      q.con[1][9] |=> toggle_output_pin == q.lat[0];
  endproperty
  a_tog_a: assert property (p_tog_a) // see R10
    else $error("core a toggle pin does not follow latch");

  property p_tog_b;
    @(posedge clock) disable iff (reset)
      q.con[4][9] |=> core_b_toggle_pin == q.lat[1];
  endproperty
  a_tog_b: assert property (p_tog_b) // see R18
    else $error("core b toggle pin does not follow latch");

  // underflow without reload must wrap to all ones
  property p_wrap_b;
    @(posedge clock) disable iff (reset)
      ev[4] && q.con[4][7] && !q.con[4][8] && !q.con[4][10] && !wr
        |=> q.cnt[4] == 16'hFFFF;
  endproperty
  a_wrap_b: assert property (p_wrap_b) // see R01
    else $error("core b did not wrap on underflow");

  c_pwm: cover property (@(posedge clock) disable iff (reset)
    ev[1] ##[1:1000] ev[1]);
  c_cap: cover property (@(posedge clock) disable iff (reset) cb);
  c_reload_a: cover property (@(posedge clock) disable iff (reset)
    q.con[0][5:3] == 3'h4 && ph[0]);
  c_rel: cover property (@(posedge clock) disable iff (reset)
    ev[4] && q.con[4][10]);

endmodule

// File: shared/dmt_defines.svh
// register map, field positions and constants of the dual module timer
`ifndef DMT_DEFINES_SVH
`define DMT_DEFINES_SVH

// ------------------------------------------------------------
// register word addresses
// ------------------------------------------------------------
`define DMT_ADDR_CON_LAST 4'h4
`define DMT_ADDR_CNT_FIRST 4'h5
`define DMT_ADDR_CNT_LAST 4'h9
`define DMT_ADDR_CAPTURE_RELOAD_REGISTER 4'hA
`define DMT_ADDR_FLAGS 4'hB
`define DMT_ADDR_STATUS 4'hC

// ------------------------------------------------------------
// control word fields
// ------------------------------------------------------------
`define DMT_F_SEL 2:0
`define DMT_F_EDGE 1:0
`define DMT_B_LATSRC 2
`define DMT_F_MODE 5:3
`define DMT_B_RUN 6
`define DMT_B_DOWN 7
`define DMT_B_EXTDIR 8
`define DMT_B_OUTEN 9
`define DMT_B_RELOAD 10
`define DMT_B_CAPEN 11
`define DMT_B_CLR 12
`define DMT_F_CAPEDGE 14:13

// ------------------------------------------------------------
// timer indices, limits, prescaler masks
// ------------------------------------------------------------
`define DMT_CORE_A 1
`define DMT_CORE_B 4
`define DMT_AUX_B 3
`define DMT_CNT_MAX 16'hFFFF
`define DMT_CNT_MIN 16'h0000
`define DMT_PRE_A_NMASK 10'h3F8
`define DMT_PRE_B_NMASK 10'h3FC
`define DMT_PIN_CAP 10
`define DMT_PIN_DIR0 5

`endif

// File: shared/dmt_pkg.sv
// types shared by the dual module timer
package dmt_pkg;

  // ------------------------------------------------------------
  // per-timer operating mode, codes follow declaration order
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_timer,
    mode_counter,
    mode_gate_low,
    mode_gate_high,
    mode_reload,
    mode_capture
  } dmt_mode_e;

  // ------------------------------------------------------------
  // whole state of the unit; index 0..4 = aux a low, core a,
  // aux a high, aux b, core b
  // ------------------------------------------------------------
  typedef struct packed {
    logic [4:0][15:0] con;
    logic [4:0][15:0] cnt;
    logic [15:0] cap;
    logic [5:0] flg;
    logic [1:0] lat;
    logic [1:0] latp;
    logic [9:0] pre;
    logic [10:0] s1;
    logic [10:0] s2;
    logic [10:0] s3;
    logic [15:0] rdata;
    logic [1:0] tog;
    logic t6ev;
  } dmt_state_s;

endpackage

// File: verification/dmt_pin_model.sv
// far-side model: timer port pins and compare/capture timer clock sink
`timescale 1ns/1ps

module dmt_pin_model (
  input wire logic clock,
  output logic [4:0] gate_pins,
  output logic [4:0] dir_pins,
  output logic cap_pin,
  input wire logic compare_capture_unit_clock,
  output logic [15:0] cc_count
);
  // index 0..4 timer pins, 5 capture pin
  logic [5:0] p;

  initial begin
    p = 6'h00;
    dir_pins = 5'h00;
    cc_count = 16'h0000;
  end

  assign gate_pins = p[4:0];
  assign cap_pin = p[5];

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // pulse kept 4 clocks per phase: shorter ones may be lost in sync
  task automatic pulse(input int i);
    @(posedge clock);
    p[i] <= 1'b1;
    repeat (4) @(posedge clock);
    p[i] <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic level(input int i, input logic v);
    @(posedge clock);
    p[i] <= v;
  endtask

  task automatic set_dir(input int i, input logic v);
    @(posedge clock);
    dir_pins[i] <= v;
  endtask

  // compare/capture timer counts each core b wrap pulse
  always @(posedge clock) begin
    if (compare_capture_unit_clock === 1'b1) begin
      cc_count <= cc_count + 16'h0001;
    end
  end
endmodule

// File: verification/tb_top.sv
// self-checking testbench of the dual module timer unit
`timescale 1ns/1ps
`include "dmt_defines.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end end

module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [4:0] gate_pins;
  logic [4:0] dir_pins;
  logic cap_pin;
  logic toggle_output_pin;
  logic core_b_toggle_pin;
  logic cc_clk;
  logic [5:0] irq_request;
  logic [15:0] cc_count;
  logic [15:0] v;
  int n_mismatch = 0;
  int checks = 0;

  initial begin
    forever #2.5 clock = ~clock;
  end

  dmt_timer_unit uut (.clock(clock), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timer_gate_clock_pin(gate_pins), .direction_control_pin(dir_pins),
    .capture_input_pin(cap_pin), .toggle_output_pin(toggle_output_pin),
    .core_b_toggle_pin(core_b_toggle_pin),
    .compare_capture_unit_clock(cc_clk), .irq_request(irq_request));

  dmt_pin_model pm (.clock(clock), .gate_pins(gate_pins),
    .dir_pins(dir_pins), .cap_pin(cap_pin),
    .compare_capture_unit_clock(cc_clk), .cc_count(cc_count));

  // ------------------------------------------------------------
  // bus and helper tasks
  // ------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    while (irq_request[b] !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) begin
      n_mismatch++;
      summarize();
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_map();
    `CHK(irq_request, 6'h00)
    rd_reg(`DMT_ADDR_FLAGS, v);
    `CHK(v, 16'h0000)
    rd_reg(4'hD, v);
    `CHK(v, 16'h0000)
    wr_reg(4'h6, 16'hFFFF);
    rd_reg(4'h6, v);
    `CHK(v, 16'hFFFF)
  endtask

  // four ticks per code; prescaler phase allows one tick of slack
  task automatic t_prescale();
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 8; c++) begin
        wr_reg(m ? 4'h9 : 4'h6, 16'h0000);
        wr_reg(m ? 4'h4 : 4'h1, 16'h0040 | 16'(c));
        repeat (4 * ((m ? 4 : 8) << c)) @(posedge clock);
        wr_reg(m ? 4'h4 : 4'h1, 16'h0000);
        rd_reg(m ? 4'h9 : 4'h6, v);
        `CHK(v >= 16'h0003 && v <= 16'h0005, 1'b1)
      end
    end
  endtask

  // every timer in turn, so each input and direction pin moves
  task automatic t_counter_dir();
    for (int i = 0; i < 5; i++) begin
      wr_reg(4'(5 + i), 16'h0000);
      wr_reg(4'(i), 16'h0049);
      repeat (3) pm.pulse(i);
      rd_reg(4'(5 + i), v);
      `CHK(v, 16'h0003)
      wr_reg(4'(i), 16'h0149);
      pm.set_dir(i, 1'b1);
      repeat (4) @(posedge clock);
      pm.pulse(i);
      rd_reg(4'(5 + i), v);
      `CHK(v, 16'h0002)
      pm.set_dir(i, 1'b0);
      wr_reg(4'(i), 16'h00C9);
      pm.pulse(i);
      rd_reg(4'(5 + i), v);
      `CHK(v, 16'h0001)
      wr_reg(4'(i), 16'h0000);
    end
  endtask

  task automatic t_gated();
    wr_reg(4'h7, 16'h0000);
    wr_reg(4'h2, 16'h0058);
    repeat (80) @(posedge clock);
    rd_reg(4'h7, v);
    `CHK(v, 16'h0000)
    pm.level(2, 1'b1);
    repeat (80) @(posedge clock);
    pm.level(2, 1'b0);
    repeat (10) @(posedge clock);
    rd_reg(4'h7, v);
    `CHK(v >= 16'h0009 && v <= 16'h000B, 1'b1)
    wr_reg(4'h7, 16'h0000);
    wr_reg(4'h2, 16'h0050);
    repeat (80) @(posedge clock);
    wr_reg(4'h2, 16'h0000);
    rd_reg(4'h7, v);
    `CHK(v >= 16'h000A && v <= 16'h000B, 1'b1)
  endtask

  task automatic t_core_a();
    wr_reg(`DMT_ADDR_FLAGS, 16'h003F);
    wr_reg(4'h6, 16'hFFFE);
    wr_reg(4'h1, 16'h0240);
    wait_flag(1);
    repeat (2) @(posedge clock);
    `CHK(toggle_output_pin, 1'b1)
    wr_reg(4'h1, 16'h0200);
    wr_reg(4'h6, 16'h5555);
    wr_reg(4'h2, 16'h0029);
    pm.pulse(2);
    rd_reg(4'h7, v);
    `CHK(v, 16'h5555)
    wr_reg(4'h5, 16'h0777);
    wr_reg(4'h0, 16'h0021);
    pm.pulse(0);
    rd_reg(4'h6, v);
    `CHK(v, 16'h0777)
  endtask

  // 2 ticks high, 4 low at divide by 8: 16 of every 48 clocks high
  task automatic t_pwm();
    logic [15:0] hi;
    hi = 16'h0000;
    wr_reg(4'h5, 16'hFFFE);
    wr_reg(4'h7, 16'hFFFC);
    wr_reg(4'h6, 16'hFFFF);
    wr_reg(4'h0, 16'h0025);
    wr_reg(4'h2, 16'h0026);
    wr_reg(4'h1, 16'h0240);
    repeat (100) @(posedge clock);
    repeat (480) begin
      @(negedge clock);
      hi = hi + 16'(toggle_output_pin);
    end
    `CHK(hi, 16'h00A0)
    wr_reg(4'h1, 16'h0000);
  endtask

  task automatic t_capture_b();
    wr_reg(4'h8, 16'h1234);
    wr_reg(4'h3, 16'h3800);
    wr_reg(`DMT_ADDR_FLAGS, 16'h003F);
    pm.pulse(5);
    `CHK(irq_request[5], 1'b1)
    rd_reg(`DMT_ADDR_CAPTURE_RELOAD_REGISTER, v);
    `CHK(v, 16'h1234)
    rd_reg(4'h8, v);
    `CHK(v, 16'h0000)
    wr_reg(4'h3, 16'h0000);
  endtask

  task automatic t_reload_b();
    wr_reg(`DMT_ADDR_CAPTURE_RELOAD_REGISTER, 16'hFFF0);
    wr_reg(4'h9, 16'hFFFF);
    wr_reg(`DMT_ADDR_FLAGS, 16'h003F);
    wr_reg(4'h4, 16'h0640);
    wait_flag(4);
    repeat (2) @(posedge clock);
    wr_reg(4'h4, 16'h0200);
    `CHK(core_b_toggle_pin, 1'b1)
    `CHK(cc_count, 16'h0001)
    rd_reg(4'h9, v);
    `CHK(v >= 16'hFFF0 && v <= 16'hFFF2, 1'b1)
    wr_reg(4'h9, 16'h0000);
    wr_reg(`DMT_ADDR_FLAGS, 16'h003F);
    wr_reg(4'h4, 16'h02C0);
    wait_flag(4);
    repeat (2) @(posedge clock);
    wr_reg(4'h4, 16'h0200);
    `CHK(core_b_toggle_pin, 1'b0)
    `CHK(cc_count, 16'h0002)
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_reset_map();
    t_prescale();
    t_counter_dir();
    t_gated();
    t_core_a();
    t_pwm();
    t_capture_b();
    t_reload_b();
    summarize();
  end
endmodule
